/* File: nvm_ctrl_regs.svh */
// Register offsets, field positions, reset values and counts for the NVM control block
//
// Notes on behaviour
// - Multi-byte EPROM programming ignores address bit 5, programming both bytes alike.
// - Multi-byte enable written only in special modes, reads zero in normal modes.
// - EPROM latch bit cannot be written while EPROM voltage bit is one.
// - EPROM latch set: writes capture address and data, EPROM reads blocked.
// - Extra columns: user array off, address bits 11:5 decoded, 4:0 ignored; special only.
// - Extra rows: user array off, address bits 5:0 decoded, 11:6 ignored; special only.
// - EPROM voltage bit writable only while latch bit is one; switches programming voltage.
// - After reset the 640-byte EEPROM sits at 0x0D80 when enabled; page relocatable.
// - Configuration byte is programmed and erased like an array byte; erased bits read one.
// - An erased EEPROM byte reads back as all ones.
// - Row erase selects the whole row; bulk erase selects the whole array.
// - While EEPROM latch is set the EEPROM leaves the memory map.
// - Low-voltage inhibit is read-only, follows enable and undervoltage, blocks programming.
// - Byte bit selects byte erase; else row bit picks 16-byte row or 640-byte bulk.
// - Erase bit one selects erase mode, zero selects read or program mode.
// - Protect bits cleared once within 64 cycles in normal modes, anytime in special.
// - Bulk-protect bit refuses bulk and row erase.
// - Config-protect bit refuses programming or erasing the configuration byte.
// - Top protect bit guards the upper 128 EEPROM bytes.
// - Four lower protect bits guard blocks of 32, 64, 128 and 288 bytes.
// - EEPROM occupies 0xD80 to 0xFFF of the page chosen by the map field.
`ifndef NVM_CTRL_REGS_SVH
`define NVM_CTRL_REGS_SVH

// Register byte offsets on the APB
`define OFF_EPROM_PROG_CTRL   8'h00
`define OFF_EEPROM_PROG_CTRL  8'h04
`define OFF_EEPROM_PROTECT    8'h08
`define OFF_EEPROM_MAP        8'h0C
`define OFF_OPTION            8'h10

// EPROM control fields
`define EP_MBE    7
`define EP_LAT    5
`define EP_XCOL   4
`define EP_XROW   3
`define EP_PGM    0
`define EP_RESET  8'h00

// EEPROM control fields
`define EE_ODD    7
`define EE_EVEN   6
`define EE_LVI    5
`define EE_BYTE   4
`define EE_ROW    3
`define EE_ERASE  2
`define EE_LAT    1
`define EE_PGM    0
`define EE_RESET  8'h00

// Protect register fields
`define BP_BULK   7
`define BP_LOW_VOLTAGE_PROTECT_ENABLE  6
`define BP_TOP    5
`define BP_CFG    4
`define BP_RESET  8'hFF

// Map and option registers
`define MAP_RESET 4'h0
`define OPT_PUMP_CLOCK_SELECT  0

// Counts and EEPROM geometry
`define PROTECT_WINDOW  7'd64
`define EE_BASE_OFFSET  12'hD80
`define EE_SIZE         10'd640
`define EE_ROW_BYTES    10'd16
`define ERASED_BYTE     8'hFF

// Protected block bounds (offsets within the array), lowest block first
`define BLK0_LO 10'd0
`define BLK0_HI 10'd31
`define BLK1_LO 10'd32
`define BLK1_HI 10'd95
`define BLK2_LO 10'd96
`define BLK2_HI 10'd223
`define BLK3_LO 10'd224
`define BLK3_HI 10'd511
`define BLK4_LO 10'd512
`define BLK4_HI 10'd639

`endif

/* File: nvm_ctrl_pkg.sv */
// Types shared by the NVM control block
package nvm_ctrl_pkg;

  // EEPROM erase extent
  typedef enum logic [1:0]
  {
    ERASE_BULK = 2'b00,
    ERASE_ROW  = 2'b01,
    ERASE_BYTE = 2'b10
  } erase_size_t;

endpackage

/* File: nvm_program_erase_control.sv */
// EPROM program and EEPROM program/erase control with APB registers
`include "nvm_ctrl_regs.svh"

module nvm_program_erase_control
  import nvm_ctrl_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Pins and configuration
  input  wire logic              special_mode_pin,
  input  wire logic              undervoltage_pin,
  input  wire logic              eeprom_enable,
  // CPU memory cycle
  input  wire logic [ADDR_W-1:0] cpu_addr,
  input  wire logic [7:0]        cpu_wdata,
  input  wire logic              cpu_wr,
  input  wire logic              cpu_eprom_sel,
  input  wire logic              cpu_config_sel,
  // EPROM array control
  output logic [ADDR_W-1:0]      eprom_prog_addr,
  output logic [7:0]             eprom_prog_data,
  output logic                   eprom_pair_program,
  output logic                   eprom_user_array_on,
  output logic                   eprom_read_enable,
  output logic                   eprom_vpp_on,
  // EEPROM array control
  output logic                   eeprom_read_select,
  output logic [9:0]             ee_op_start,
  output logic [9:0]             ee_op_len,
  output logic [7:0]             ee_op_data,
  output logic                   ee_op_config,
  output logic                   ee_hv_on,
  output logic                   pump_clock_select
);

  // Register state
  logic [7:0] eprom_prog_ctrl;
  logic [7:0] eeprom_prog_ctrl;
  logic [7:0] eeprom_protect_reg;
  logic [3:0] eeprom_page_field;
  logic       map_written;
  logic [6:0] reset_age;
  logic       protect_cleared;
  logic       low_voltage_inhibit;
  // Synchronisers
  logic special_meta;
  logic special_mode;
  logic uv_meta;
  logic uv_sync;
  // Latched EEPROM operation
  logic       ee_op_valid;
  logic       ee_op_erase;
  erase_size_t ee_op_size;
  // Bus decode
  logic       wr_en;
  logic       setup;
  logic       known_addr;
  logic [7:0] next_rdata;
  // Memory-side decode
  logic       eprom_latch;
  logic       ee_hit;
  logic [9:0] ee_off;
  logic [9:0] next_start;
  logic [9:0] next_len;
  erase_size_t next_size;
  logic [9:0] op_end;
  logic [4:0] blk_hit;
  logic       op_allowed;
  // Named fields
  wire logic       multi_byte_enable          = eprom_prog_ctrl[`EP_MBE];
  wire logic       extra_column_select        = eprom_prog_ctrl[`EP_XCOL];
  wire logic       extra_row_select           = eprom_prog_ctrl[`EP_XROW];
  wire logic       eprom_voltage_on           = eprom_prog_ctrl[`EP_PGM];
  wire logic       eeprom_latch               = eeprom_prog_ctrl[`EE_LAT];
  wire logic       eeprom_voltage_on          = eeprom_prog_ctrl[`EE_PGM];
  wire logic       low_voltage_protect_enable = eeprom_protect_reg[`BP_LOW_VOLTAGE_PROTECT_ENABLE];
  wire logic       bulk_erase_protect         = eeprom_protect_reg[`BP_BULK];
  wire logic       config_protect             = eeprom_protect_reg[`BP_CFG];
  wire logic       upper_block_protect        = eeprom_protect_reg[`BP_TOP];
  wire logic [3:0] lower_block_protects       = eeprom_protect_reg[3:0];
  // APB phase decode
  assign setup      = psel & ~penable;
  assign wr_en      = psel & penable & pready & pwrite & clk_en;
  assign known_addr = (paddr == `OFF_EPROM_PROG_CTRL) || (paddr == `OFF_EEPROM_PROG_CTRL) ||
                      (paddr == `OFF_EEPROM_PROTECT) || (paddr == `OFF_EEPROM_MAP) ||
                      (paddr == `OFF_OPTION);

  // Two-stage synchronisers for mode and supply pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      special_meta <= 1'b0;
      special_mode <= 1'b0;
      uv_meta      <= 1'b0;
      uv_sync      <= 1'b0;
    end
    else if (clk_en)
    begin
      special_meta <= special_mode_pin;
      special_mode <= special_meta;
      uv_meta      <= undervoltage_pin;
      uv_sync      <= uv_meta;
    end
  end

  // Read mux; fields hidden in normal modes read zero
  always_comb
  begin
    next_rdata = 8'h00;
    case (paddr)
      `OFF_EPROM_PROG_CTRL:
      begin
        next_rdata              = eprom_prog_ctrl;
        next_rdata[`EP_MBE]     = multi_byte_enable & special_mode;
        next_rdata[`EP_XCOL]    = extra_column_select & special_mode;
        next_rdata[`EP_XROW]    = extra_row_select & special_mode;
      end
      `OFF_EEPROM_PROG_CTRL:
      begin
        next_rdata          = eeprom_prog_ctrl;
        next_rdata[`EE_LVI] = low_voltage_inhibit;
      end
      `OFF_EEPROM_PROTECT:  next_rdata = eeprom_protect_reg;
      `OFF_EEPROM_MAP:      next_rdata = {eeprom_page_field, 4'h0};
      `OFF_OPTION:          next_rdata = {7'h00, pump_clock_select};
      default:              next_rdata = 8'h00;
    endcase
  end

  // APB answer: one access cycle, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= setup;
      pslverr <= setup & ~known_addr;
      if (setup)
        prdata <= {24'h00_0000, next_rdata};
    end
  end

  // EPROM control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eprom_prog_ctrl <= `EP_RESET;
    else if (wr_en && paddr == `OFF_EPROM_PROG_CTRL)
    begin
      if (special_mode)
      begin
        eprom_prog_ctrl[`EP_MBE]  <= pwdata[`EP_MBE];
        eprom_prog_ctrl[`EP_XCOL] <= pwdata[`EP_XCOL];
        eprom_prog_ctrl[`EP_XROW] <= pwdata[`EP_XROW];
      end
      if (!eprom_voltage_on)
        eprom_prog_ctrl[`EP_LAT] <= pwdata[`EP_LAT];
      if (eprom_prog_ctrl[`EP_LAT])
        eprom_prog_ctrl[`EP_PGM] <= pwdata[`EP_PGM];
    end
  end

  // EEPROM control register; inhibit bit is not stored here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eeprom_prog_ctrl <= `EE_RESET;
    else if (wr_en && paddr == `OFF_EEPROM_PROG_CTRL)
    begin
      eeprom_prog_ctrl           <= pwdata[7:0];
      eeprom_prog_ctrl[`EE_LVI]  <= 1'b0;
    end
  end

  // Reset age counter for the protect clearing window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_age <= 7'd0;
    else if (clk_en && reset_age != `PROTECT_WINDOW)
      reset_age <= reset_age + 7'd1;
  end

  // Protect register: setting always, clearing gated in normal modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eeprom_protect_reg <= `BP_RESET;
      protect_cleared    <= 1'b0;
    end
    else if (wr_en && paddr == `OFF_EEPROM_PROTECT)
    begin
      if (special_mode)
        eeprom_protect_reg <= pwdata[7:0];
      else if (!protect_cleared && reset_age < `PROTECT_WINDOW)
      begin
        eeprom_protect_reg <= pwdata[7:0];
        protect_cleared    <= 1'b1;
      end
      else
        eeprom_protect_reg <= eeprom_protect_reg | pwdata[7:0];
    end
  end

  // EEPROM page register, write-once in normal modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eeprom_page_field <= `MAP_RESET;
      map_written       <= 1'b0;
    end
    else if (wr_en && paddr == `OFF_EEPROM_MAP && (special_mode || !map_written))
    begin
      eeprom_page_field <= pwdata[7:4];
      map_written       <= 1'b1;
    end
  end

  // Charge-pump clock source select, set by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pump_clock_select <= 1'b0;
    else if (wr_en && paddr == `OFF_OPTION)
      pump_clock_select <= pwdata[`OPT_PUMP_CLOCK_SELECT];
  end

  // Low-voltage inhibit follows enable and synchronised undervoltage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_voltage_inhibit <= 1'b0;
    else if (clk_en)
      low_voltage_inhibit <= low_voltage_protect_enable & uv_sync;
  end

  // EPROM latch is void while the EEPROM latch is set
  assign eprom_latch = eprom_prog_ctrl[`EP_LAT] & ~eeprom_latch;

  // EPROM address/data capture with multi-byte and extra row/column masking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eprom_prog_addr <= '0;
      eprom_prog_data <= 8'h00;
    end
    else if (clk_en && eprom_latch && cpu_wr && cpu_eprom_sel)
    begin
      eprom_prog_data <= cpu_wdata;
      eprom_prog_addr <= cpu_addr;
      if (multi_byte_enable)
        eprom_prog_addr[5] <= 1'b0;
      if (extra_column_select)
        eprom_prog_addr[4:0] <= 5'h00;
      else if (extra_row_select)
        eprom_prog_addr[11:6] <= 6'h00;
    end
  end

  // EPROM array steering outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eprom_pair_program  <= 1'b0;
      eprom_user_array_on <= 1'b1;
      eprom_read_enable   <= 1'b1;
      eprom_vpp_on        <= 1'b0;
    end
    else if (clk_en)
    begin
      eprom_pair_program  <= multi_byte_enable;
      eprom_user_array_on <= ~(extra_column_select | extra_row_select);
      eprom_read_enable   <= ~eprom_latch;
      eprom_vpp_on        <= eprom_voltage_on;
    end
  end

  // EEPROM window decode in the selected page
  assign ee_hit = (cpu_addr[15:12] == eeprom_page_field) && (cpu_addr[11:0] >= `EE_BASE_OFFSET);
  assign ee_off = 10'(cpu_addr[11:0] - `EE_BASE_OFFSET);

  // Visible in the map only when enabled and not latched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eeprom_read_select <= 1'b0;
    else if (clk_en)
      eeprom_read_select <= ee_hit & eeprom_enable & ~eeprom_latch;
  end

  // Erase extent from byte and row bits
  always_comb
  begin
    next_size  = ERASE_BULK;
    next_start = 10'd0;
    next_len   = `EE_SIZE;
    if (!eeprom_prog_ctrl[`EE_ERASE] || eeprom_prog_ctrl[`EE_BYTE])
    begin
      next_size  = ERASE_BYTE;
      next_start = ee_off;
      next_len   = 10'd1;
    end
    else if (eeprom_prog_ctrl[`EE_ROW])
    begin
      next_size  = ERASE_ROW;
      next_start = {ee_off[9:4], 4'h0};
      next_len   = `EE_ROW_BYTES;
    end
  end

  // Latch the EEPROM or configuration byte operation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ee_op_valid  <= 1'b0;
      ee_op_erase  <= 1'b0;
      ee_op_config <= 1'b0;
      ee_op_size   <= ERASE_BULK;
      ee_op_start  <= 10'd0;
      ee_op_len    <= 10'd0;
      ee_op_data   <= 8'h00;
    end
    else if (clk_en)
    begin
      if (!eeprom_latch)
        ee_op_valid <= 1'b0;
      else if (cpu_wr && (cpu_config_sel || ee_hit))
      begin
        ee_op_valid  <= 1'b1;
        ee_op_erase  <= eeprom_prog_ctrl[`EE_ERASE];
        ee_op_config <= cpu_config_sel;
        ee_op_size   <= cpu_config_sel ? ERASE_BYTE : next_size;
        ee_op_start  <= cpu_config_sel ? 10'd0 : next_start;
        ee_op_len    <= cpu_config_sel ? 10'd1 : next_len;
        ee_op_data   <= eeprom_prog_ctrl[`EE_ERASE] ? `ERASED_BYTE : cpu_wdata;
      end
    end
  end

  // Overlap of the operation with each protected block
  assign op_end = 10'(ee_op_start + ee_op_len - 10'd1);
  localparam logic [9:0] BLK_LO [5] = '{`BLK0_LO, `BLK1_LO, `BLK2_LO, `BLK3_LO, `BLK4_LO};
  localparam logic [9:0] BLK_HI [5] = '{`BLK0_HI, `BLK1_HI, `BLK2_HI, `BLK3_HI, `BLK4_HI};
  generate
    for (genvar gi = 0; gi < 5; gi++)
    begin : g_blk
      logic prot;
      if (gi == 4)
        assign prot = upper_block_protect;
      else
        assign prot = lower_block_protects[gi];
      assign blk_hit[gi] = prot && (ee_op_start <= BLK_HI[gi]) && (op_end >= BLK_LO[gi]);
    end
  endgenerate

  // Refuse protected, bulk-protected or inhibited operations
  always_comb
  begin
    op_allowed = ee_op_valid & ~low_voltage_inhibit;
    if (ee_op_config)
      op_allowed = op_allowed & ~config_protect;
    else if (|blk_hit || (ee_op_erase && ee_op_size != ERASE_BYTE && bulk_erase_protect))
      op_allowed = 1'b0;
  end

  // High voltage to the EEPROM array only for an allowed latched operation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ee_hv_on <= 1'b0;
    else if (clk_en)
      ee_hv_on <= eeprom_voltage_on & eeprom_latch & op_allowed;
  end
endmodule

/* File: nvm_pec_checker.sv */
// Concurrent checks on the NVM program and erase control ports
module nvm_pec_checker
  import nvm_ctrl_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [7:0]        paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  // CPU cycle
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [7:0]        cpu_wdata,
  input wire logic              cpu_wr,
  input wire logic              cpu_eprom_sel,
  input wire logic              eeprom_enable,
  // Array control
  input wire logic [ADDR_W-1:0] eprom_prog_addr,
  input wire logic [7:0]        eprom_prog_data,
  input wire logic              eprom_pair_program,
  input wire logic              eprom_read_enable,
  input wire logic              eeprom_read_select,
  input wire logic [9:0]        ee_op_start,
  input wire logic [9:0]        ee_op_len,
  input wire logic [7:0]        ee_op_data,
  input wire logic              ee_op_config,
  input wire logic              ee_hv_on
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Offset of the CPU address within its page
  logic [11:0] addr_low;
  assign addr_low = cpu_addr[11:0];

  // Bus steps and EPROM capture
  sequence apb_setup; psel && !penable && clk_en; endsequence
  sequence apb_access; psel && penable && pready; endsequence
  sequence eprom_cap; cpu_wr && cpu_eprom_sel && clk_en && !eprom_read_enable; endsequence

  apb_ready_a: assert property (apb_setup |=> apb_access) // zero wait states
    else $error("access phase without ready");
  unmapped_err_a: assert property ((apb_access ##0 (paddr > 8'h10 || paddr[1:0] != 2'b00)) |-> pslverr) // unmapped
    else $error("unmapped access without error");
  pair_prog_a: assert property ((eprom_cap ##0 eprom_pair_program) |=>
    eprom_prog_addr[5] == 1'b0 && eprom_prog_data == $past(cpu_wdata)) else $error("pair address bit set");
  ee_window_a: assert property (eeprom_read_select |->
    $past(eeprom_enable) && $past(addr_low) >= 12'hD80) else $error("select outside window");
  row_align_a: assert property (ee_op_len == 10'd16 |->
    ee_op_start[3:0] == 4'h0 && ee_op_data == 8'hFF) else $error("row not aligned");
  bulk_whole_a: assert property (ee_op_len == 10'd640 |->
    ee_op_start == 10'd0 && ee_op_data == 8'hFF) else $error("bulk not whole array");
  config_byte_a: assert property (ee_op_config && ee_op_len != 10'd0 |->
    ee_op_start == 10'd0 && ee_op_len == 10'd1) else $error("config op not one byte");
  hv_cause_a: assert property (ee_hv_on |-> ee_op_len != 10'd0)
    else $error("voltage without latched op");
endmodule

bind nvm_program_erase_control nvm_pec_checker #(.ADDR_W(ADDR_W)) nvm_pec_checker_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
  .cpu_eprom_sel(cpu_eprom_sel), .eeprom_enable(eeprom_enable), .eprom_prog_addr(eprom_prog_addr),
  .eprom_prog_data(eprom_prog_data), .eprom_pair_program(eprom_pair_program),
  .eprom_read_enable(eprom_read_enable), .eeprom_read_select(eeprom_read_select),
  .ee_op_start(ee_op_start), .ee_op_len(ee_op_len), .ee_op_data(ee_op_data),
  .ee_op_config(ee_op_config), .ee_hv_on(ee_hv_on));

/* File: nvm_program_erase_control_tb.sv */
// Self-checking testbench for the NVM program and erase control block
module nvm_program_erase_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_ctrl_pkg::*;

  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, cpu_wdata, eprom_prog_data, ee_op_data;
  logic [31:0] pwdata, prdata, rd;
  logic        special_mode_pin, undervoltage_pin, eeprom_enable, cpu_wr, cpu_eprom_sel, cpu_config_sel;
  logic [15:0] cpu_addr, eprom_prog_addr;
  logic        eprom_pair_program, eprom_user_array_on, eprom_read_enable, eprom_vpp_on, err;
  logic        eeprom_read_select, ee_op_config, ee_hv_on, pump_clock_select;
  logic [9:0]  ee_op_start, ee_op_len;
  int          failures, cmp_count;

  nvm_program_erase_control nvm_program_erase_control_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode_pin(special_mode_pin), .undervoltage_pin(undervoltage_pin), .eeprom_enable(eeprom_enable),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_eprom_sel(cpu_eprom_sel),
    .cpu_config_sel(cpu_config_sel), .eprom_prog_addr(eprom_prog_addr), .eprom_prog_data(eprom_prog_data),
    .eprom_pair_program(eprom_pair_program), .eprom_user_array_on(eprom_user_array_on),
    .eprom_read_enable(eprom_read_enable), .eprom_vpp_on(eprom_vpp_on), .eeprom_read_select(eeprom_read_select),
    .ee_op_start(ee_op_start), .ee_op_len(ee_op_len), .ee_op_data(ee_op_data), .ee_op_config(ee_op_config),
    .ee_hv_on(ee_hv_on), .pump_clock_select(pump_clock_select));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Let edges pass, then sample settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // One APB transfer, held until ready
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] exp);
    apb(a, 1'b0, 8'h00);
    check(n, rd, {24'h0, exp});
  endtask

  // One CPU write cycle
  task automatic cpu(input logic [15:0] a, input logic [7:0] d, input logic cfg, input logic ep);
    @(posedge pclk);
    cpu_addr <= a; cpu_wdata <= d; cpu_wr <= 1'b1; cpu_config_sel <= cfg; cpu_eprom_sel <= ep;
    @(posedge pclk);
    cpu_wr <= 1'b0; cpu_config_sel <= 1'b0; cpu_eprom_sel <= 1'b0;
    settle(1);
  endtask

  // Full EEPROM program or erase sequence
  task automatic ee_op(input logic [7:0] c, input logic [15:0] a, input logic cfg,
                       input logic [9:0] st, input logic [9:0] ln, input logic hv);
    wr(8'h04, c);
    cpu(a, 8'h5A, cfg, 1'b0);
    check("op_start", ee_op_start, st);
    check("op_len", ee_op_len, ln);
    check("op_data", ee_op_data, c[2] ? 8'hFF : 8'h5A);
    check("op_config", ee_op_config, cfg);
    wr(8'h04, c | 8'h01);
    settle(2);
    check("hv_on", ee_hv_on, hv);
    wr(8'h04, c);
    wr(8'h04, 8'h00);
  endtask

  // Window select seen one cycle after the address
  task automatic sel_chk(input logic [15:0] a, input logic exp);
    @(posedge pclk);
    cpu_addr <= a;
    settle(2);
    check("read_select", eeprom_read_select, exp);
  endtask

  // Reset values, unmapped offset, protect clear once
  task automatic s_reset_protect();
    rdchk("eprom_ctrl", 8'h00, 8'h00);
    rdchk("eeprom_ctrl", 8'h04, 8'h00);
    rdchk("protect", 8'h08, 8'hFF);
    rdchk("map", 8'h0C, 8'h00);
    apb(8'h14, 1'b0, 8'h00);
    check("unmapped_err", err, 1'b1);
    wr(8'h08, 8'h00);
    rdchk("protect", 8'h08, 8'h00);
    wr(8'h08, 8'h40);
    rdchk("protect", 8'h08, 8'h40);
    wr(8'h08, 8'h00);
    rdchk("protect", 8'h08, 8'h40);
  endtask

  // Program, map presence, latch removal, erase sizes, pump clock
  task automatic s_eeprom();
    logic [7:0] ctl [4] = '{8'h16, 8'h1E, 8'h0E, 8'h06};
    logic [9:0] st [4] = '{10'd35, 10'd35, 10'd32, 10'd0};
    logic [9:0] ln [4] = '{10'd1, 10'd1, 10'd16, 10'd640};
    ee_op(8'h02, 16'h0D85, 1'b0, 10'd5, 10'd1, 1'b1);
    sel_chk(16'h0D85, 1'b1);
    wr(8'h04, 8'h02);
    sel_chk(16'h0D85, 1'b0);
    wr(8'h04, 8'h00);
    eeprom_enable <= 1'b0;
    sel_chk(16'h0D85, 1'b0);
    @(posedge pclk) eeprom_enable <= 1'b1;
    for (int i = 0; i < 4; i++)
      ee_op(ctl[i], 16'h0DA3, 1'b0, st[i], ln[i], 1'b1);
    wr(8'h10, 8'h01);
    settle(1);
    check("pump_clk", pump_clock_select, 1'b1);
  endtask

  // EPROM control in normal mode
  task automatic s_eprom_normal();
    wr(8'h00, 8'h98);
    rdchk("eprom_ctrl", 8'h00, 8'h00);
    wr(8'h00, 8'h01);
    rdchk("eprom_ctrl", 8'h00, 8'h00);
    wr(8'h00, 8'h20);
    cpu(16'h1234, 8'h3C, 1'b0, 1'b1);
    check("eprom_rd_en", eprom_read_enable, 1'b0);
    check("eprom_addr", eprom_prog_addr, 16'h1234);
    check("eprom_data", eprom_prog_data, 8'h3C);
    wr(8'h00, 8'h21);
    settle(2);
    check("vpp", eprom_vpp_on, 1'b1);
    wr(8'h00, 8'h01);
    rdchk("eprom_ctrl", 8'h00, 8'h21);
    wr(8'h00, 8'h20);
    wr(8'h00, 8'h00);
    settle(2);
    check("vpp", eprom_vpp_on, 1'b0);
    check("eprom_rd_en", eprom_read_enable, 1'b1);
  endtask

  // Special mode: EPROM test fields, map, protection and inhibit
  task automatic s_special();
    logic [7:0]  ctl [3] = '{8'hA0, 8'h30, 8'h28};
    logic [15:0] ea [3] = '{16'h1214, 16'h1220, 16'h1034};
    logic [7:0]  bit_v [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
    logic [9:0]  off [5] = '{10'd0, 10'd32, 10'd96, 10'd224, 10'd512};
    @(posedge pclk) special_mode_pin <= 1'b1;
    settle(3);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, ctl[i]);
      rdchk("eprom_ctrl", 8'h00, ctl[i]);
      cpu(16'h1234, 8'h3C, 1'b0, 1'b1);
      check("eprom_addr", eprom_prog_addr, ea[i]);
      check("pair", eprom_pair_program, ctl[i][7]);
      check("user_array", eprom_user_array_on, !(ctl[i][4] | ctl[i][3]));
      wr(8'h00, 8'h00);
    end
    wr(8'h0C, 8'h30);
    sel_chk(16'h3D90, 1'b1);
    sel_chk(16'h0D90, 1'b0);
    wr(8'h0C, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h08, 8'h40 | bit_v[i]);
      ee_op(8'h02, 16'h0D80 + {6'h0, off[i]}, 1'b0, off[i], 10'd1, 1'b0);
      wr(8'h08, 8'h40);
      ee_op(8'h02, 16'h0D80 + {6'h0, off[i]}, 1'b0, off[i], 10'd1, 1'b1);
    end
    wr(8'h08, 8'hC0);
    ee_op(8'h06, 16'h0D90, 1'b0, 10'd0, 10'd640, 1'b0);
    ee_op(8'h0E, 16'h0D90, 1'b0, 10'd16, 10'd16, 1'b0);
    wr(8'h08, 8'h50);
    ee_op(8'h02, 16'h003F, 1'b1, 10'd0, 10'd1, 1'b0);
    wr(8'h08, 8'h40);
    ee_op(8'h06, 16'h003F, 1'b1, 10'd0, 10'd1, 1'b1);
    undervoltage_pin <= 1'b1;
    settle(4);
    rdchk("eeprom_ctrl", 8'h04, 8'h20);
    ee_op(8'h02, 16'h0D85, 1'b0, 10'd5, 10'd1, 1'b0);
    wr(8'h08, 8'h00);
    rdchk("eeprom_ctrl", 8'h04, 8'h00);
    ee_op(8'h02, 16'h0D85, 1'b0, 10'd5, 10'd1, 1'b1);
  endtask

  // Main sequence
  initial
  begin
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; special_mode_pin = 1'b0; undervoltage_pin = 1'b0; eeprom_enable = 1'b1;
    cpu_addr = 16'h0; cpu_wdata = 8'h00; cpu_wr = 1'b0; cpu_eprom_sel = 1'b0; cpu_config_sel = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    s_reset_protect();
    s_eeprom();
    s_eprom_normal();
    s_special();
    finish_test();
  end
endmodule
